// ### rtl/ocx_regs.sv
//
// Functional notes
// - Limits are 16-bit signed two's complement
// - Sample above high limit raises high event
// - High limit 7FFF disables; reset value
// - Sample below low limit raises low event
// - Low limit 8000 disables; reset value
// - Spare word RW, resets 5555, inert
// - Aux disable zeroes result and step counter
// - Standby or power-down zeroes same state
// - Bit 10 drives common-mode buffer on input seven
// - Source route selects input n, reset zero
// - Sink route selects input n, reset one
// - Source magnitude off/4/40/240 uA, reset off
// - Sink magnitude off/4/40/240 uA, reset off
// - Fault output on either event, chosen polarity
// - Trip after consecutive count, restart on fallback
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module ocx_regs
   import ocx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Fast-filter samples from the first current converter
   input wire logic sample_valid,
   input wire logic [15:0] sample,
   // Auxiliary converter datapath
   input wire logic low_power,
   input wire logic aux_result_valid,
   input wire logic [15:0] aux_result_in,
   input wire logic aux_step_done,
   // Outputs
   output logic high_limit_trip_event,
   output logic low_limit_trip_event,
   output logic overcurrent_fault_output,
   output logic aux_converter_enable,
   output logic common_mode_buffer_enable,
   output logic [7:0] open_wire_source_route,
   output logic [7:0] open_wire_sink_route,
   output ocx_pkg::ocx_mag_e open_wire_source_magnitude,
   output ocx_pkg::ocx_mag_e open_wire_sink_magnitude,
   output logic [15:0] aux_result,
   output logic [1:0] aux_sequence_step_counter
);
   import ocx_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] hi_r, hi_nxt;
   logic [15:0] lo_r, lo_nxt;
   logic [15:0] spare_r, spare_nxt;
   logic [15:0] cfg1_r, cfg1_nxt;
   logic [15:0] cmp_r, cmp_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic wr_hi, wr_lo, wr_spare, wr_cfg1, wr_cmp;

   assign wr_hi = reg_wr && (reg_addr == ADDR_HIGH_LIMIT);
   assign wr_lo = reg_wr && (reg_addr == ADDR_LOW_LIMIT);
   assign wr_spare = reg_wr && (reg_addr == ADDR_SPARE);
   assign wr_cfg1 = reg_wr && (reg_addr == ADDR_AUX_CFG1);
   assign wr_cmp = reg_wr && (reg_addr == ADDR_CMP_CFG);

   always_comb begin
      hi_nxt = wr_hi ? reg_wdata : hi_r;
      lo_nxt = wr_lo ? reg_wdata : lo_r;
      spare_nxt = wr_spare ? reg_wdata : spare_r;
      cfg1_nxt = wr_cfg1 ? (reg_wdata & AUX_CFG1_WMASK) : cfg1_r;
      cmp_nxt = wr_cmp ? (reg_wdata & CMP_CFG_WMASK) : cmp_r;
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [15:0] status_word;
   logic ht_q, lt_q, fault_q;
   logic [15:0] aux_res_w;
   logic [1:0] aux_step_w;

   assign status_word = {11'h000, aux_step_w, fault_q, lt_q, ht_q};

   always_comb begin
      rdata_nxt = ZERO16;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_HIGH_LIMIT: rdata_nxt = hi_r;
            ADDR_LOW_LIMIT: rdata_nxt = lo_r;
            ADDR_SPARE: rdata_nxt = spare_r;
            ADDR_AUX_CFG1: rdata_nxt = cfg1_r;
            ADDR_CMP_CFG: rdata_nxt = cmp_r;
            ADDR_STATUS: rdata_nxt = status_word;
            default: rdata_nxt = ZERO16;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         hi_r <= RST_HIGH_LIMIT;
         lo_r <= RST_LOW_LIMIT;
         spare_r <= RST_SPARE;
         cfg1_r <= RST_AUX_CFG1;
         cmp_r <= RST_CMP_CFG;
         rdata_r <= ZERO16;
      end else begin
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
         spare_r <= spare_nxt;
         cfg1_r <= cfg1_nxt;
         cmp_r <= cmp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Overcurrent comparators
   // ----------------------------------------
   ocx_trip_if hi_if();
   ocx_trip_if lo_if();
   logic [6:0] need_w;

   assign need_w = ocx_trip_count(cmp_r[CNT_HI:CNT_LO]);

   assign hi_if.sample_valid = sample_valid;
   assign hi_if.sample = sample;
   assign hi_if.limit = hi_r;
   assign hi_if.above = 1'b1;
   assign hi_if.need = need_w;

   assign lo_if.sample_valid = sample_valid;
   assign lo_if.sample = sample;
   assign lo_if.limit = lo_r;
   assign lo_if.above = 1'b0;
   assign lo_if.need = need_w;

   ocx_trip_det u_hi (
      .clk(clk),
      .nrst(nrst),
      .tp(hi_if.det)
   );

   ocx_trip_det u_lo (
      .clk(clk),
      .nrst(nrst),
      .tp(lo_if.det)
   );

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   logic fault_nxt;
   logic ht_nxt, lt_nxt;

   always_comb begin
      ht_nxt = hi_if.trip;
      lt_nxt = lo_if.trip;
      fault_nxt = (hi_if.trip || lo_if.trip) ~^ cmp_r[POL_BIT];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ht_q <= 1'b0;
         lt_q <= 1'b0;
         // Active-low at reset, so no fault shows
         fault_q <= 1'b1;
      end else begin
         ht_q <= ht_nxt;
         lt_q <= lt_nxt;
         fault_q <= fault_nxt;
      end
   end

   // ----------------------------------------
   // Auxiliary converter state
   // ----------------------------------------
   // Host keeps config stable while enabled; no lockout here
   ocx_aux_ctrl u_aux (
      .clk(clk),
      .nrst(nrst),
      .aux_on(cfg1_r[AUX_EN_BIT]),
      .low_power(low_power),
      .result_valid(aux_result_valid),
      .result_in(aux_result_in),
      .step_done(aux_step_done),
      .result(aux_res_w),
      .step(aux_step_w)
   );

   // Analog control mirrors, registered
   logic cm_q;
   logic [7:0] src_q, snk_q;
   logic [1:0] srcm_q, snkm_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cm_q <= 1'b0;
         src_q <= 8'h01;
         snk_q <= 8'h02;
         srcm_q <= 2'h0;
         snkm_q <= 2'h0;
      end else begin
         cm_q <= cfg1_r[CM_BUF_BIT];
         src_q <= ocx_route(cfg1_r[SRC_ROUTE_HI:SRC_ROUTE_LO]);
         snk_q <= ocx_route(cfg1_r[SNK_ROUTE_HI:SNK_ROUTE_LO]);
         srcm_q <= cfg1_r[SRC_MAG_HI:SRC_MAG_LO];
         snkm_q <= cfg1_r[SNK_MAG_HI:SNK_MAG_LO];
      end
   end

   assign reg_rdata = rdata_r;
   assign high_limit_trip_event = ht_q;
   assign low_limit_trip_event = lt_q;
   assign overcurrent_fault_output = fault_q;
   assign aux_converter_enable = cfg1_r[AUX_EN_BIT];
   assign common_mode_buffer_enable = cm_q;
   assign open_wire_source_route = src_q;
   assign open_wire_sink_route = snk_q;
   assign open_wire_source_magnitude = ocx_mag_e'(srcm_q);
   assign open_wire_sink_magnitude = ocx_mag_e'(snkm_q);
   assign aux_result = aux_res_w;
   assign aux_sequence_step_counter = aux_step_w;
endmodule // ocx_regs

// ### common/ocx_pkg.sv
package ocx_pkg;
   // Register indices (word addresses on the register port)
   localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h88;
   localparam logic [7:0] ADDR_LOW_LIMIT = 8'h89;
   localparam logic [7:0] ADDR_SPARE = 8'h8A;
   localparam logic [7:0] ADDR_AUX_CFG1 = 8'h8B;
   localparam logic [7:0] ADDR_CMP_CFG = 8'hC0;
   localparam logic [7:0] ADDR_STATUS = 8'hC1;

   // Reset values
   localparam logic [15:0] RST_HIGH_LIMIT = 16'h7FFF;
   localparam logic [15:0] RST_LOW_LIMIT = 16'h8000;
   localparam logic [15:0] RST_SPARE = 16'h5555;
   localparam logic [15:0] RST_AUX_CFG1 = 16'h8010;
   localparam logic [15:0] RST_CMP_CFG = 16'h0000;
   localparam logic [15:0] ZERO16 = 16'h0000;

   // Disable codes for the two limits
   localparam logic signed [15:0] POS_FULL_SCALE = 16'sh7FFF;
   localparam logic signed [15:0] NEG_FULL_SCALE = -16'sh8000;

   // Auxiliary configuration field layout
   localparam int AUX_EN_BIT = 15;
   localparam int CM_BUF_BIT = 10;
   localparam int SRC_ROUTE_HI = 9;
   localparam int SRC_ROUTE_LO = 7;
   localparam int SNK_ROUTE_HI = 6;
   localparam int SNK_ROUTE_LO = 4;
   localparam int SRC_MAG_HI = 3;
   localparam int SRC_MAG_LO = 2;
   localparam int SNK_MAG_HI = 1;
   localparam int SNK_MAG_LO = 0;
   localparam logic [15:0] AUX_CFG1_WMASK = 16'h87FF;

   // Comparator configuration layout (bit 14 polarity, 12:8 count code)
   localparam int POL_BIT = 14;
   localparam int CNT_HI = 12;
   localparam int CNT_LO = 8;
   localparam logic [15:0] CMP_CFG_WMASK = 16'h5F00;

   // Counter widths
   localparam logic [6:0] CNT_ONE = 7'h01;
   localparam logic [1:0] SEQ_ZERO = 2'h0;

   typedef enum logic [1:0] {
      OCX_MAG_OFF,
      OCX_MAG_4UA,
      OCX_MAG_40UA,
      OCX_MAG_240UA
   } ocx_mag_e;

   // Consecutive-sample count for a deglitch code
   function automatic logic [6:0] ocx_trip_count(input logic [4:0] code);
      logic [6:0] n;
      n = 7'h01;
      unique case (code)
         5'h00: n = 7'h01;
         5'h01: n = 7'h02;
         5'h02: n = 7'h03;
         5'h03: n = 7'h04;
         5'h04: n = 7'h05;
         5'h05: n = 7'h06;
         5'h06: n = 7'h07;
         5'h07: n = 7'h08;
         5'h08: n = 7'h0A;
         5'h09: n = 7'h0C;
         5'h0A: n = 7'h0E;
         5'h0B: n = 7'h10;
         5'h0C: n = 7'h12;
         5'h0D: n = 7'h14;
         5'h0E: n = 7'h16;
         5'h0F: n = 7'h18;
         5'h10: n = 7'h1A;
         5'h11: n = 7'h1C;
         5'h12: n = 7'h1E;
         5'h13: n = 7'h20;
         5'h14: n = 7'h28;
         5'h15: n = 7'h30;
         5'h16: n = 7'h38;
         5'h17: n = 7'h40;
         5'h18: n = 7'h48;
         5'h19: n = 7'h50;
         5'h1A: n = 7'h58;
         5'h1B: n = 7'h60;
         5'h1C: n = 7'h68;
         5'h1D: n = 7'h70;
         5'h1E: n = 7'h78;
         5'h1F: n = 7'h7F;
      endcase
      return n;
   endfunction

   // One-hot select of one of eight auxiliary inputs
   function automatic logic [7:0] ocx_route(input logic [2:0] sel);
      return 8'h01 << sel;
   endfunction
endpackage

// ### common/ocx_trip_if.sv
`timescale 1ns/100ps
interface ocx_trip_if;
   logic sample_valid;
   logic signed [15:0] sample;
   logic signed [15:0] limit;
   logic above;
   logic [6:0] need;
   logic trip;

   modport ctrl (output sample_valid, output sample, output limit, output above, output need, input trip);
   modport det (input sample_valid, input sample, input limit, input above, input need, output trip);
endinterface

// ### rtl/ocx_trip_det.sv
`timescale 1ns/100ps
module ocx_trip_det
   import ocx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Comparator link
   ocx_trip_if.det tp
);
   import ocx_pkg::*;

   logic [6:0] cnt_r, cnt_nxt;
   logic trip_r, trip_nxt;
   logic beyond;

   always_comb begin
      if (tp.above) begin
         beyond = (tp.limit != POS_FULL_SCALE) && (tp.sample > tp.limit);
      end else begin
         beyond = (tp.limit != NEG_FULL_SCALE) && (tp.sample < tp.limit);
      end
   end

   always_comb begin
      cnt_nxt = cnt_r;
      trip_nxt = trip_r;
      if (tp.sample_valid) begin
         if (!beyond) begin
            cnt_nxt = 7'h00;
            trip_nxt = 1'b0;
         end else begin
            if (cnt_r < tp.need) begin
               cnt_nxt = cnt_r + CNT_ONE;
            end
            // Widened so a full count of 127 cannot wrap and drop the trip
            trip_nxt = ({1'b0, cnt_r} + {1'b0, CNT_ONE}) >= {1'b0, tp.need};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_r <= 7'h00;
         trip_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         trip_r <= trip_nxt;
      end
   end

   assign tp.trip = trip_r;
endmodule // ocx_trip_det

// ### rtl/ocx_aux_ctrl.sv
`timescale 1ns/100ps
module ocx_aux_ctrl
   import ocx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic aux_on,
   input wire logic low_power,
   input wire logic result_valid,
   input wire logic [15:0] result_in,
   input wire logic step_done,
   // State
   output logic [15:0] result,
   output logic [1:0] step
);
   import ocx_pkg::*;

   logic [15:0] res_r, res_nxt;
   logic [1:0] seq_r, seq_nxt;

   always_comb begin
      res_nxt = res_r;
      seq_nxt = seq_r;
      if (!aux_on || low_power) begin
         res_nxt = ZERO16;
         seq_nxt = SEQ_ZERO;
      end else begin
         if (result_valid) begin
            res_nxt = result_in;
         end
         if (step_done) begin
            seq_nxt = seq_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         res_r <= ZERO16;
         seq_r <= SEQ_ZERO;
      end else begin
         res_r <= res_nxt;
         seq_r <= seq_nxt;
      end
   end

   assign result = res_r;
   assign step = seq_r;
endmodule // ocx_aux_ctrl

// ### dv/ocx_host_model.sv
`timescale 1ns/100ps
module ocx_host_model
   import ocx_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Called just after an edge; returns just after the edge that took the strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Released lines flip so stale values never pass for live ones
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule // ocx_host_model

// ### dv/ocx_regs_properties.sv
`timescale 1ns/100ps
module ocx_regs_properties
   import ocx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Datapath
   input wire logic sample_valid,
   input wire logic low_power,
   input wire logic aux_result_valid,
   input wire logic [15:0] aux_result_in,
   input wire logic aux_step_done,
   // Outputs
   input wire logic high_limit_trip_event,
   input wire logic low_limit_trip_event,
   input wire logic overcurrent_fault_output,
   input wire logic aux_converter_enable,
   input wire logic common_mode_buffer_enable,
   input wire logic [7:0] open_wire_source_route,
   input wire logic [7:0] open_wire_sink_route,
   input wire logic [15:0] aux_result,
   input wire logic [1:0] aux_sequence_step_counter
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic cfg_wr;
   logic any_ev;
   assign cfg_wr = reg_wr && reg_addr == ADDR_AUX_CFG1;
   assign any_ev = high_limit_trip_event | low_limit_trip_event;
   sequence aux_off_s;
      !aux_converter_enable || low_power;
   endsequence
   sequence aux_run_s;
      aux_converter_enable && !low_power;
   endsequence
   sequence cfg_read_s;
      reg_rd && reg_addr == ADDR_AUX_CFG1;
   endsequence
   cfg_rsvd_zero_a:
      assert property (cfg_read_s |=> reg_rdata[14:11] == 4'h0) else $error("reserved config bits set");
   route_onehot_a:
      assert property ($onehot(open_wire_source_route) && $onehot(open_wire_sink_route))
      else $error("route not one-hot");
   // Routes and common-mode buffer change only two cycles after a config write
   route_cause_a:
      assert property ($changed({open_wire_source_route, open_wire_sink_route, common_mode_buffer_enable})
                       |-> $past(cfg_wr, 2)) else $error("routing moved without config write");
   high_cause_a:
      assert property ($changed(high_limit_trip_event) |-> $past(sample_valid, 2)) else $error("high event moved");
   low_cause_a:
      assert property ($changed(low_limit_trip_event) |-> $past(sample_valid, 2)) else $error("low event moved");
   fault_follow_a:
      assert property ($changed(any_ev) |-> $changed(overcurrent_fault_output)) else $error("fault lags event");
   aux_clear_a:
      assert property (aux_off_s |=> aux_result == ZERO16 && aux_sequence_step_counter == SEQ_ZERO)
      else $error("aux state not cleared");
   step_adv_a:
      assert property (aux_run_s ##0 aux_step_done |=> aux_sequence_step_counter == $past(aux_sequence_step_counter) + 2'h1)
      else $error("step counter did not advance");
   result_load_a:
      assert property (aux_run_s ##0 aux_result_valid |=> aux_result == $past(aux_result_in))
      else $error("aux result not loaded");
endmodule // ocx_regs_properties

bind ocx_regs ocx_regs_properties u_ocx_regs_properties (.clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
   .sample_valid, .low_power, .aux_result_valid, .aux_result_in, .aux_step_done, .high_limit_trip_event,
   .low_limit_trip_event, .overcurrent_fault_output, .aux_converter_enable, .common_mode_buffer_enable,
   .open_wire_source_route, .open_wire_sink_route, .aux_result, .aux_sequence_step_counter);

// ### dv/ocx_regs_bench.sv
`timescale 1ns/100ps
module ocx_regs_bench;
   import ocx_pkg::*;
   logic clk, nrst, reg_wr, reg_rd, sample_valid, low_power, aux_result_valid, aux_step_done;
   logic [7:0] reg_addr, a;
   logic [15:0] reg_wdata, reg_rdata, sample, aux_result_in, aux_result, d;
   logic high_limit_trip_event, low_limit_trip_event, overcurrent_fault_output;
   logic aux_converter_enable, common_mode_buffer_enable;
   logic [7:0] open_wire_source_route, open_wire_sink_route;
   ocx_mag_e open_wire_source_magnitude, open_wire_sink_magnitude;
   logic [1:0] aux_sequence_step_counter;
   logic [15:0] lfsr_r = 16'h4C9E;
   int failures = 0;
   int checks_done = 0;

   ocx_host_model u_ocx_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   ocx_regs u_ocx_regs (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid,
      .sample, .low_power, .aux_result_valid, .aux_result_in, .aux_step_done, .high_limit_trip_event,
      .low_limit_trip_event, .overcurrent_fault_output, .aux_converter_enable, .common_mode_buffer_enable,
      .open_wire_source_route, .open_wire_sink_route, .open_wire_source_magnitude, .open_wire_sink_magnitude,
      .aux_result, .aux_sequence_step_counter);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
      u_ocx_host_model.wr(ad, dt);
   endtask
   task automatic rdchk(input logic [7:0] ad, input logic [15:0] e);
      logic [15:0] v;
      u_ocx_host_model.rd(ad, v);
      check(v, e);
   endtask
   // Three edges of slack cover the trip pipeline; events hold until a clean sample
   task automatic samp(input logic [15:0] v, input logic [1:0] e, input logic pol);
      sample_valid <= 1'b1;
      sample <= v;
      @(posedge clk);
      sample_valid <= 1'b0;
      sample <= ~v;
      repeat (3) @(posedge clk);
      #1;
      check({high_limit_trip_event, low_limit_trip_event, overcurrent_fault_output}, {e, (|e) ~^ pol});
   endtask
   task automatic aux(input logic st, input logic ld, input logic lp, input logic [15:0] v, input logic [17:0] e);
      aux_step_done <= st;
      aux_result_valid <= ld;
      low_power <= lp;
      aux_result_in <= v;
      @(posedge clk);
      aux_step_done <= 1'b0;
      aux_result_valid <= 1'b0;
      low_power <= 1'b0;
      aux_result_in <= ~v;
      #1;
      check({aux_sequence_step_counter, aux_result}, e);
   endtask

   initial begin
      #800000;
      failures++;
      report_and_stop();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      sample_valid = 1'b0;
      sample = 16'h0000;
      low_power = 1'b0;
      aux_result_valid = 1'b0;
      aux_result_in = 16'h0000;
      aux_step_done = 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      rdchk(ADDR_HIGH_LIMIT, RST_HIGH_LIMIT);
      rdchk(ADDR_LOW_LIMIT, RST_LOW_LIMIT);
      rdchk(ADDR_SPARE, RST_SPARE);
      rdchk(ADDR_AUX_CFG1, RST_AUX_CFG1);
      rdchk(8'h00, ZERO16);
      check({open_wire_source_route, open_wire_sink_route}, 18'h00102);
      check({aux_converter_enable, open_wire_source_magnitude, open_wire_sink_magnitude}, 18'h10);
      for (int i = 0; i < 12; i++) begin
         lfsr_r = lfsr_next(lfsr_r);
         a = ADDR_HIGH_LIMIT + 8'(i % 3);
         wr(a, lfsr_r);
         rdchk(a, lfsr_r);
      end
      // Every route and magnitude code, enable kept clear
      for (int i = 0; i < 8; i++) begin
         lfsr_r = lfsr_next(lfsr_r);
         d = {1'b0, lfsr_r[14:10], 3'(i), 3'(~i), 2'(i), 2'(~i)};
         wr(ADDR_AUX_CFG1, d);
         rdchk(ADDR_AUX_CFG1, d & AUX_CFG1_WMASK);
         check({open_wire_source_route, open_wire_sink_route}, {8'h01 << d[9:7], 8'h01 << d[6:4]});
         check({aux_converter_enable, common_mode_buffer_enable, open_wire_source_magnitude,
                open_wire_sink_magnitude}, {d[15], d[10], d[3:0]});
      end
      aux(1'b1, 1'b1, 1'b0, 16'h1234, 18'h0);
      wr(ADDR_AUX_CFG1, RST_AUX_CFG1);
      aux(1'b1, 1'b0, 1'b0, 16'h0000, 18'h10000);
      aux(1'b1, 1'b0, 1'b0, 16'h0000, 18'h20000);
      aux(1'b1, 1'b1, 1'b0, lfsr_r, {2'h3, lfsr_r});
      aux(1'b1, 1'b1, 1'b1, 16'hBEEF, 18'h0);
      aux(1'b1, 1'b1, 1'b0, 16'hBEEF, 18'h1BEEF);
      wr(ADDR_AUX_CFG1, 16'h0010);
      aux(1'b0, 1'b0, 1'b0, 16'h0000, 18'h0);
      wr(ADDR_CMP_CFG, 16'h4000);
      wr(ADDR_HIGH_LIMIT, 16'h0100);
      wr(ADDR_LOW_LIMIT, 16'hFF00);
      samp(16'h0100, 2'b00, 1'b1);
      samp(16'h0101, 2'b10, 1'b1);
      samp(16'h8000, 2'b01, 1'b1);
      samp(16'hFF00, 2'b00, 1'b1);
      samp(16'hFEFF, 2'b01, 1'b1);
      rdchk(ADDR_STATUS, 16'h0006);
      rdchk(ADDR_CMP_CFG, 16'h4000);
      wr(ADDR_HIGH_LIMIT, RST_HIGH_LIMIT);
      wr(ADDR_LOW_LIMIT, RST_LOW_LIMIT);
      samp(16'h7FFF, 2'b00, 1'b1);
      samp(16'h8000, 2'b00, 1'b1);
      wr(ADDR_CMP_CFG, 16'h0300);
      wr(ADDR_HIGH_LIMIT, 16'h0100);
      for (int i = 0; i < 8; i++) begin
         samp(i == 3 ? 16'h0000 : 16'h0200, {i == 7, 1'b0}, 1'b0);
      end
      report_and_stop();
   end
endmodule // ocx_regs_bench
